// File: logic/voice_recorder_pin_control.sv
// Device end: control-pin logic of the voice record/playback device
//
// Operation
// - Overflow pulses low at array end
// - Then overflow follows chip enable until standby
// - Host drives chip enable low to operate
// - Latch address and play select on enable fall
// - Host holds standby high when idle
// - Standby after overflow returns pointer to start
// - End marker written, kept until recorded over
// - End output pulses low fixed width
// - Low supply forces end low, playback only
// - Push-button mode: end pin is busy high
// - Idle external clock selects internal oscillator
// - Unused external clock tied to ground
// - External clock divided by two on entry
// - External clock matches variant sample rate
// - Address bits 8 and 7 both high select modes
// - Pointer zeroed on direction change (not in consecutive push-button mode), standby
`timescale 1ns/1ps
`default_nettype none
`include "voice_link_defs.svh"
module voice_recorder_pin_control #(
    parameter int ADDR_W         = `ADDR_W,
    parameter int SUB_W          = `SUB_W,
    parameter int INT_TICK_CYC   = `INT_TICK_CYC,
    parameter int EXT_PRESCALE   = `EXT_PRESCALE,
    parameter int EXT_IDLE_CYC   = `EXT_IDLE_CYC,
    parameter int END_PULSE_CYC  = `END_PULSE_CYC,
    parameter int FULL_PULSE_CYC = `FULL_PULSE_CYC
)(
    input  wire logic                 core_clk,      // Core clock
    input  wire logic                 rst,           // Async reset, active high
    voice_link_if.device              link,          // Pins toward the host
    input  wire logic                 supply_low,    // Supply monitor, async level
    output logic                      busy,          // Operation in progress
    output logic                      recording,     // Record in progress
    output logic                      ext_in_use,    // External clock selected
    output logic                      overflowed,    // Overflow held until standby
    output logic [`MODE_W-1:0]        mode_bits      // Latched mode bits
);
    import voice_link_pkg::*;

    localparam int PTR_W = ADDR_W + SUB_W;
    localparam int ROWS  = 1 << ADDR_W;
    localparam int SW    = ADDR_W + 5;
    localparam logic [SW-1:0] SYNC_IDLE = {3'h7, 2'h0, {ADDR_W{1'b0}}}; // Idle pin levels
    localparam int ICW   = $clog2(INT_TICK_CYC + 1);
    localparam int ECW   = $clog2(EXT_PRESCALE + 1);
    localparam int DCW   = $clog2(EXT_IDLE_CYC + 1);
    localparam int PCW   = $clog2(END_PULSE_CYC + FULL_PULSE_CYC + 1);

    // ==========================================
    // Pin synchronisers
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic          ce_s;
    logic          std_s;
    logic          pr_s;
    logic          ext_s;
    logic          lowv_s;
    logic [ADDR_W-1:0] addr_s;
    logic          ce_prev_r;
    logic          ext_prev_r;
    logic          std_prev_r;

    // Two flops on every pin before use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_r <= SYNC_IDLE; // No false edge or low supply after reset
            sync2_r <= SYNC_IDLE;
        end else begin
            sync1_r <= {link.chip_enable_n, link.standby_request, link.play_record,
                        link.ext_sample_clock, supply_low, link.addr};
            sync2_r <= sync1_r;
        end
    end
    assign {ce_s, std_s, pr_s, ext_s, lowv_s, addr_s} = sync2_r;

    // Previous levels for edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ce_prev_r  <= 1'b1;
            ext_prev_r <= 1'b0;
            std_prev_r <= 1'b1;
        end else begin
            ce_prev_r  <= ce_s;
            ext_prev_r <= ext_s;
            std_prev_r <= std_s;
        end
    end

    // ==========================================
    // Sample clock selection
    logic [ICW-1:0] int_cnt_r;
    logic [ECW-1:0] pre_cnt_r;
    logic [DCW-1:0] idle_cnt_r;
    logic           half_r;
    logic           ext_rise;
    logic           int_tick;
    logic           ext_tick;
    logic           ext_used;
    logic           tick;

    assign ext_rise = ext_s & ~ext_prev_r;
    assign int_tick = (int_cnt_r == ICW'(INT_TICK_CYC - 1));
    assign ext_tick = ext_rise & half_r & (pre_cnt_r == ECW'(EXT_PRESCALE - 1));
    assign ext_used = (idle_cnt_r < DCW'(EXT_IDLE_CYC));
    assign tick     = ext_used ? ext_tick : int_tick;

    // Internal oscillator and external clock dividers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int_cnt_r  <= '0;
            pre_cnt_r  <= '0;
            half_r     <= 1'b0;
            idle_cnt_r <= DCW'(EXT_IDLE_CYC);
        end else begin
            int_cnt_r <= int_tick ? '0 : int_cnt_r + 1'b1;
            if (ext_rise) begin
                half_r     <= ~half_r;
                idle_cnt_r <= '0;
                if (half_r) begin
                    pre_cnt_r <= ext_tick ? '0 : pre_cnt_r + 1'b1;
                end
            end else if (!ext_used) begin
                idle_cnt_r <= idle_cnt_r;
            end else begin
                idle_cnt_r <= idle_cnt_r + 1'b1;
            end
        end
    end

    // ==========================================
    // Operation control and address pointer
    dev_state_t        state_r;
    logic [PTR_W-1:0]  ptr_r;
    logic [`MODE_W-1:0] mode_r;
    logic              last_rec_r;
    logic              ovf_hold_r;
    logic [ROWS-1:0]   marker_r;
    logic              ce_fall;
    logic              mode_req;
    logic              want_rec;
    logic              ptr_end;
    logic              row_mark;
    logic              msg_end;
    logic              full_evt;
    logic              rec_end;
    logic              start;
    logic [PTR_W-1:0]  start_ptr;
    logic [ADDR_W-1:0] row;

    assign row      = ptr_r[PTR_W-1 -: ADDR_W];
    assign ce_fall  = ce_prev_r & ~ce_s;
    assign start    = ce_fall & ~std_s & ~ovf_hold_r & (state_r == DEV_IDLE);
    assign mode_req = addr_s[`MODE_HI_BIT] & addr_s[`MODE_LO_BIT];
    assign want_rec = ~pr_s & ~lowv_s;
    assign ptr_end  = &ptr_r;
    assign row_mark = marker_r[row] & (&ptr_r[SUB_W-1:0]);

    // Event decode for the current sample tick
    always_comb begin
        msg_end  = tick & (state_r == DEV_PLAY) & row_mark;
        full_evt = tick & (state_r != DEV_IDLE) & ptr_end & ~msg_end
                   & ~((state_r == DEV_PLAY) & mode_r[`M3_LOOP]);
        rec_end  = (state_r == DEV_REC) & (ce_s | std_s | full_evt);
        if (!mode_req) begin
            start_ptr = {addr_s, {SUB_W{1'b0}}};
        end else if (addr_s[`M4_CONSEC] && ((last_rec_r == want_rec) || addr_s[`M6_PUSH])) begin
            start_ptr = ptr_r;
        end else begin
            start_ptr = '0;
        end
    end

    // Operation state, pointer and latched controls
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r    <= DEV_IDLE;
            ptr_r      <= '0;
            mode_r     <= '0;
            last_rec_r <= 1'b0;
            ovf_hold_r <= 1'b0;
        end else if (std_s) begin
            state_r <= DEV_IDLE;
            ptr_r   <= '0;
            ovf_hold_r <= full_evt | (ovf_hold_r & std_prev_r); // Set wins
        end else if (start) begin
            mode_r     <= mode_req ? addr_s[`MODE_W-1:0] : '0;
            last_rec_r <= want_rec;
            ptr_r      <= start_ptr;
            state_r    <= want_rec ? DEV_REC : DEV_PLAY;
        end else if (full_evt) begin
            state_r    <= DEV_IDLE;
            ovf_hold_r <= 1'b1;
        end else if (msg_end) begin
            state_r <= DEV_IDLE;
            ptr_r   <= mode_r[`M4_CONSEC] ? ptr_r + 1'b1 : '0;
        end else if (rec_end) begin
            state_r <= DEV_IDLE;
        end else if ((state_r == DEV_PLAY) && mode_r[`M5_LEVEL] && ce_s) begin
            state_r <= DEV_IDLE;
        end else if (tick && (state_r != DEV_IDLE)) begin
            ptr_r <= ptr_r + 1'b1;
        end
    end

    // End markers: cleared as rows are recorded over, set at record end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            marker_r <= '0;
        end else if (rec_end) begin
            marker_r[row] <= 1'b1;
        end else if (tick && (state_r == DEV_REC)) begin
            marker_r[row] <= 1'b0;
        end
    end

    // ==========================================
    // Output pulses and pin drivers
    logic [PCW-1:0] eom_cnt_r;
    logic [PCW-1:0] full_cnt_r;
    logic           eom_n_r;
    logic           full_n_r;

    // Pulse width counters
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eom_cnt_r  <= '0;
            full_cnt_r <= '0;
        end else begin
            if (msg_end) begin
                eom_cnt_r <= PCW'(END_PULSE_CYC);
            end else if (eom_cnt_r != '0) begin
                eom_cnt_r <= eom_cnt_r - 1'b1;
            end
            if (full_evt) begin
                full_cnt_r <= PCW'(FULL_PULSE_CYC);
            end else if (full_cnt_r != '0) begin
                full_cnt_r <= full_cnt_r - 1'b1;
            end
        end
    end

    // Registered pins and status
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eom_n_r    <= 1'b1;
            full_n_r   <= 1'b1;
            busy       <= 1'b0;
            recording  <= 1'b0;
            ext_in_use <= 1'b0;
            overflowed <= 1'b0;
            mode_bits  <= '0;
        end else begin
            if (lowv_s) begin
                eom_n_r <= 1'b0;
            end else if (mode_r[`M6_PUSH]) begin
                eom_n_r <= (state_r != DEV_IDLE);
            end else begin
                eom_n_r <= (eom_cnt_r == '0);
            end
            if (full_cnt_r != '0) begin
                full_n_r <= 1'b0;
            end else begin
                full_n_r <= ovf_hold_r ? ce_s : 1'b1;
            end
            busy       <= (state_r != DEV_IDLE);
            recording  <= (state_r == DEV_REC);
            ext_in_use <= ext_used;
            overflowed <= ovf_hold_r;
            mode_bits  <= mode_r;
        end
    end
    assign link.message_end_n     = eom_n_r;
    assign link.array_full_flag_n = full_n_r;
endmodule // voice_recorder_pin_control
`default_nettype wire

// File: logic/voice_link_defs.svh
// Widths, field positions, reset values and timing counts of the voice recorder link
`ifndef VOICE_LINK_DEFS_SVH
`define VOICE_LINK_DEFS_SVH
// ==========================================
// Widths and field positions
`define ADDR_W          10
`define SUB_W           4
`define MODE_HI_BIT     8
`define MODE_LO_BIT     7
`define MODE_W          7
`define M3_LOOP         3
`define M4_CONSEC       4
`define M5_LEVEL        5
`define M6_PUSH         6
// ==========================================
// Timing
`define CORE_CLK_MHZ    250
`define END_PULSE_NS    12500
`define END_PULSE_CYC   ((`END_PULSE_NS * `CORE_CLK_MHZ) / 1000)
`define FULL_PULSE_NS   12500
`define FULL_PULSE_CYC  ((`FULL_PULSE_NS * `CORE_CLK_MHZ) / 1000)
`define SAMPLE_HZ       8000
`define INT_TICK_CYC    ((`CORE_CLK_MHZ * 1000000) / `SAMPLE_HZ)
`define EXT_PRESCALE    64
`define EXT_IDLE_NS     4000
`define EXT_IDLE_CYC    ((`EXT_IDLE_NS * `CORE_CLK_MHZ) / 1000)
`define EXT_HALF_CYC    122
`define SETUP_NS        100
`define SETUP_CYC       (((`SETUP_NS * `CORE_CLK_MHZ) + 999) / 1000)
`define RESET_VAL_CE_N  1'b1
`define RESET_VAL_STBY  1'b1
`endif

// File: logic/voice_link_pkg.sv
// Types shared by both ends of the voice recorder link
package voice_link_pkg;
    // ==========================================
    // Device operation states (Gray along idle-record-play)
    typedef enum logic [1:0] {
        DEV_IDLE = 2'b00,
        DEV_REC  = 2'b01,
        DEV_PLAY = 2'b11
    } dev_state_t;
    // ==========================================
    // Host sequencing states (Gray ring)
    typedef enum logic [1:0] {
        HOST_IDLE    = 2'b00,
        HOST_SETUP   = 2'b01,
        HOST_ACTIVE  = 2'b11,
        HOST_RELEASE = 2'b10
    } host_state_t;
endpackage

// File: logic/voice_link_if.sv
// Pin-level link between the recorder device and its controlling party
`timescale 1ns/1ps
`default_nettype none
`include "voice_link_defs.svh"
interface voice_link_if #(
    parameter int ADDR_W = `ADDR_W
);
    logic              chip_enable_n;       // Active-low enable, host driven
    logic              standby_request;     // Power-down request, host driven
    logic              play_record;         // High selects playback, host driven
    logic [ADDR_W-1:0] addr;                // Message address or mode bits
    logic              ext_sample_clock;    // Optional external clock, low when unused
    logic              array_full_flag_n;   // Overflow output, device driven
    logic              message_end_n;       // End of message or busy, device driven
    modport device (
        input  chip_enable_n, standby_request, play_record, addr, ext_sample_clock,
        output array_full_flag_n, message_end_n
    );
    modport host (
        output chip_enable_n, standby_request, play_record, addr, ext_sample_clock,
        input  array_full_flag_n, message_end_n
    );
endinterface
`default_nettype wire

// File: logic/voice_recorder_host.sv
// Host end: controller that sequences the recorder device pins
`timescale 1ns/1ps
`default_nettype none
`include "voice_link_defs.svh"
module voice_recorder_host #(
    parameter int ADDR_W       = `ADDR_W,
    parameter int SETUP_CYC    = `SETUP_CYC,
    parameter int EXT_HALF_CYC = `EXT_HALF_CYC,
    parameter bit USE_EXT      = 1'b0
)(
    input  wire logic              core_clk,    // Core clock
    input  wire logic              rst,         // Async reset, active high
    voice_link_if.host             link,        // Pins toward the device
    input  wire logic              start_req,   // One-cycle start pulse
    input  wire logic              play_sel,    // High selects playback
    input  wire logic [ADDR_W-1:0] start_addr,  // Address or mode bits
    input  wire logic              stop_req,    // One-cycle stop pulse
    output logic                   busy,        // Operation sequencing
    output logic                   full_seen,   // Device overflow seen
    output logic                   msg_done     // One-cycle end-of-message pulse
);
    import voice_link_pkg::*;

    localparam int SCW = $clog2(SETUP_CYC + 2);
    localparam int XCW = $clog2(EXT_HALF_CYC + 1);

    // ==========================================
    // Device output synchronisers
    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] prev_r;
    logic       full_fall;
    logic       eom_fall;

    // Two flops, then edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_r   <= 2'b11;
            s2_r   <= 2'b11;
            prev_r <= 2'b11;
        end else begin
            s1_r   <= {link.array_full_flag_n, link.message_end_n};
            s2_r   <= s1_r;
            prev_r <= s2_r;
        end
    end
    assign full_fall = prev_r[1] & ~s2_r[1];
    assign eom_fall  = prev_r[0] & ~s2_r[0];

    // ==========================================
    // Pin sequencing
    host_state_t       state_r;
    logic [SCW-1:0]    cnt_r;
    logic              ce_n_r;
    logic              stby_r;
    logic              pr_r;
    logic [ADDR_W-1:0] addr_r;

    // Setup, active and release phases
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r   <= HOST_IDLE;
            cnt_r     <= '0;
            ce_n_r    <= `RESET_VAL_CE_N;
            stby_r    <= `RESET_VAL_STBY;
            pr_r      <= 1'b1;
            addr_r    <= '0;
            busy      <= 1'b0;
            full_seen <= 1'b0;
            msg_done  <= 1'b0;
        end else begin
            msg_done <= eom_fall;
            case (state_r)
                HOST_IDLE: begin
                    ce_n_r <= 1'b1;
                    stby_r <= 1'b1;
                    busy   <= 1'b0;
                    if (start_req) begin
                        pr_r      <= play_sel;
                        addr_r    <= start_addr;
                        stby_r    <= 1'b0;
                        cnt_r     <= '0;
                        busy      <= 1'b1;
                        full_seen <= 1'b0;
                        state_r   <= HOST_SETUP;
                    end
                end
                HOST_SETUP: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == SCW'(SETUP_CYC)) begin
                        ce_n_r  <= 1'b0;
                        state_r <= HOST_ACTIVE;
                    end
                end
                HOST_ACTIVE: begin
                    if (full_fall) begin
                        full_seen <= 1'b1;
                        ce_n_r    <= 1'b1;
                        stby_r    <= 1'b1;
                        cnt_r     <= '0;
                        state_r   <= HOST_RELEASE;
                    end else if (stop_req || eom_fall) begin
                        ce_n_r  <= 1'b1;
                        cnt_r   <= '0;
                        state_r <= HOST_RELEASE;
                    end
                end
                HOST_RELEASE: begin
                    cnt_r <= cnt_r + 1'b1;
                    if (cnt_r == SCW'(SETUP_CYC)) begin
                        stby_r  <= 1'b1;
                        state_r <= HOST_IDLE;
                    end
                end
                default: begin
                    state_r <= HOST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // External sample clock source
    logic [XCW-1:0] xcnt_r;
    logic           ext_sample_clock_r;

    // Divider when enabled, otherwise held at ground
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xcnt_r <= '0;
            ext_sample_clock_r <= 1'b0;
        end else if (!USE_EXT) begin
            ext_sample_clock_r <= 1'b0;
        end else if (xcnt_r == XCW'(EXT_HALF_CYC - 1)) begin
            xcnt_r <= '0;
            ext_sample_clock_r <= ~ext_sample_clock_r;
        end else begin
            xcnt_r <= xcnt_r + 1'b1;
        end
    end

    assign link.chip_enable_n    = ce_n_r;
    assign link.standby_request  = stby_r;
    assign link.play_record      = pr_r;
    assign link.addr             = addr_r;
    assign link.ext_sample_clock = ext_sample_clock_r;
endmodule // voice_recorder_host
`default_nettype wire

// File: testbench/voice_link_checker.sv
// Concurrent checks on the pins between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module voice_link_checker #(
    parameter int ADDR_W = 10
)(
    input wire logic              core_clk,          // Core clock
    input wire logic              rst,               // Async reset, active high
    input wire logic              chip_enable_n,     // Enable pin
    input wire logic              standby_request,   // Power-down pin
    input wire logic              play_record,       // Play select pin
    input wire logic [ADDR_W-1:0] addr,              // Address pins
    input wire logic              ext_sample_clock,  // External clock pin
    input wire logic              array_full_flag_n, // Overflow pin
    input wire logic              message_end_n      // End-of-message pin
);
    // ==========================================
    // One clock domain for every property
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Enable goes low a fixed setup time after standby drops
    property p_setup;
        $fell(standby_request) |-> chip_enable_n [*3] ##1 !chip_enable_n;
    endproperty
    a_setup: assert property (p_setup) else $error("enable setup after standby wrong");

    // Enable is never low during standby
    property p_ce_awake;
        !chip_enable_n |-> !standby_request;
    endproperty
    a_ce_awake: assert property (p_ce_awake) else $error("enable low in standby");

    // Address and play select hold while enable is low
    property p_addr_hold;
        !chip_enable_n && !$past(chip_enable_n) |-> $stable(addr) && $stable(play_record);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved while enabled");

    // Overflow only falls while the device is awake
    property p_full_awake;
        $fell(array_full_flag_n) |-> !standby_request;
    endproperty
    a_full_awake: assert property (p_full_awake) else $error("overflow fell in standby");

    // Overflow makes the host raise standby promptly
    property p_full_standby;
        $fell(array_full_flag_n) |-> ##[1:6] standby_request;
    endproperty
    a_full_standby: assert property (p_full_standby) else $error("no standby after overflow");

    // Overflow ends the enabled operation
    property p_full_ce;
        $fell(array_full_flag_n) |-> ##[1:6] chip_enable_n;
    endproperty
    a_full_ce: assert property (p_full_ce) else $error("enable held after overflow");

    // End-of-message stays low for at least the pulse width
    property p_eom_width;
        $fell(message_end_n) |-> !message_end_n [*8];
    endproperty
    a_eom_width: assert property (p_eom_width) else $error("end pulse too short");

    // End of message releases the enable
    property p_eom_ce;
        $fell(message_end_n) && !chip_enable_n |-> ##[1:6] chip_enable_n;
    endproperty
    a_eom_ce: assert property (p_eom_ce) else $error("enable held after end of message");

    // Standby returns soon after enable rises
    property p_release;
        $rose(chip_enable_n) |-> ##[0:4] standby_request;
    endproperty
    a_release: assert property (p_release) else $error("standby late after enable rise");

    // Unused external clock stays grounded
    property p_ext_idle;
        !ext_sample_clock;
    endproperty
    a_ext_idle: assert property (p_ext_idle) else $error("external clock not grounded");
endmodule // voice_link_checker
`default_nettype wire

// File: testbench/voice_recorder_pin_control_test.sv
// Testbench joining host and device ends of the voice recorder link
`timescale 1ns/1ps
`default_nettype none
`include "voice_link_defs.svh"
module voice_recorder_pin_control_test;
    logic               core_clk   = 1'b0;
    logic               rst        = 1'b1;
    logic               start_req  = 1'b0;
    logic               play_sel   = 1'b0;
    logic [9:0]         start_addr = 10'h000;
    logic               stop_req   = 1'b0;
    logic               supply_low = 1'b0;
    logic               done_seen  = 1'b0;
    logic               dev_busy, recording, ext_in_use, overflowed;
    logic               host_busy, full_seen, msg_done;
    logic [`MODE_W-1:0] mode_bits;
    int                 bad_count  = 0;
    int                 n_tests    = 0;
    // ==========================================
    // Clock, both ends and the checker
    always #2 core_clk = ~core_clk;
    voice_link_if link ();
    voice_recorder_pin_control #(.SUB_W(1), .INT_TICK_CYC(20), .END_PULSE_CYC(8),
        .FULL_PULSE_CYC(8)) voice_recorder_pin_control_i (
        .core_clk(core_clk), .rst(rst), .link(link), .supply_low(supply_low), .busy(dev_busy),
        .recording(recording), .ext_in_use(ext_in_use), .overflowed(overflowed),
        .mode_bits(mode_bits));
    voice_recorder_host #(.SETUP_CYC(2))
        voice_recorder_host_i (.core_clk(core_clk), .rst(rst), .link(link),
        .start_req(start_req), .play_sel(play_sel), .start_addr(start_addr),
        .stop_req(stop_req), .busy(host_busy), .full_seen(full_seen), .msg_done(msg_done));
    voice_link_checker voice_link_checker_i (.core_clk(core_clk), .rst(rst),
        .chip_enable_n(link.chip_enable_n), .standby_request(link.standby_request),
        .play_record(link.play_record), .addr(link.addr),
        .ext_sample_clock(link.ext_sample_clock), .array_full_flag_n(link.array_full_flag_n),
        .message_end_n(link.message_end_n));
    // Remember any end-of-message pulse seen by the host
    always @(posedge core_clk) if (msg_done === 1'b1) done_seen <= 1'b1;
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return dev_busy;
            1: return host_busy;
            2: return link.message_end_n;
            default: return full_seen;
        endcase
    endfunction
    // Bounded wait for a watched signal to reach a level
    task automatic wait_for(input int w, input logic lvl, input int lim);
        for (int i = 0; i < lim && pick(w) !== lvl; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (pick(w) !== lvl) begin
            bad_count++;
            $display("Error at %0t: wait %0d got %h expected %h", $time, w, pick(w), lvl);
            results();
        end
    endtask
    task automatic op(input logic play, input logic [9:0] a);
        @(posedge core_clk);
        start_req  <= 1'b1;
        play_sel   <= play;
        start_addr <= a;
        @(posedge core_clk);
        start_req <= 1'b0;
        wait_for(0, 1'b1, 60);
    endtask
    task automatic halt;
        @(posedge core_clk);
        stop_req <= 1'b1;
        @(posedge core_clk);
        stop_req <= 1'b0;
        wait_for(1, 1'b0, 200);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        chk(link.chip_enable_n, 1'b1);
        chk(link.standby_request, 1'b1);
        chk(link.array_full_flag_n, 1'b1);
        chk(link.message_end_n, 1'b1);
        chk(ext_in_use, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_record;
        op(1'b0, 10'h002);
        chk(recording, 1'b1);
        repeat (100) @(posedge core_clk);
        halt();
        chk(dev_busy, 1'b0);
        $display("test record done");
    endtask
    task automatic t_play;
        int w;
        op(1'b1, 10'h002);
        chk(recording, 1'b0);
        wait_for(2, 1'b0, 2000);
        for (w = 1; link.message_end_n === 1'b0 && w < 50; w++) begin
            @(posedge core_clk);
            #1;
        end
        chk(w >= 8 && w <= 9, 1'b1);
        wait_for(1, 1'b0, 200);
        chk(done_seen, 1'b1);
        $display("test play done");
    endtask
    task automatic t_overflow;
        op(1'b0, 10'h37F);
        wait_for(3, 1'b1, 8000);
        wait_for(1, 1'b0, 200);
        chk(overflowed, 1'b0);
        chk(link.standby_request, 1'b1);
        @(posedge core_clk);
        #1;
        chk(link.array_full_flag_n, 1'b1);
        $display("test overflow done");
    endtask
    task automatic t_mode6;
        op(1'b1, 10'h1C0);
        chk(mode_bits, 7'h40);
        chk(link.message_end_n, 1'b1);
        wait_for(0, 1'b0, 2000);
        repeat (2) @(posedge core_clk);
        chk(link.message_end_n, 1'b0);
        wait_for(1, 1'b0, 200);
        $display("test push-button done");
    endtask
    task automatic t_supply;
        @(posedge core_clk);
        supply_low <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk(link.message_end_n, 1'b0);
        op(1'b0, 10'h004);
        chk(recording, 1'b0);
        halt();
        chk(link.message_end_n, 1'b0);
        $display("test supply done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        t_reset();
        t_record();
        t_play();
        t_overflow();
        t_mode6();
        t_supply();
        results();
    end
endmodule // voice_recorder_pin_control_test
`default_nettype wire
